// [hw/rx_pcs_lane_status_pkg.sv]
// Constants shared by the receive PCS lane status logic
package rx_pcs_lane_status_pkg;
	// ==========================================================
	// Geometry
	localparam int NUM_LANES = 20;
	localparam int BLK_W = 66;
	localparam int BLKS_PER_CYCLE = 4;
	localparam int PARITY_W = 8;
	localparam int MISMATCH_W = 3;
	// ==========================================================
	// Block field positions (sync in low bits, then payload LSB first)
	localparam int SYNC_LSB = 0;
	localparam int TYPE_LSB = 2;
	localparam int SEQ_D3_LSB = 26;
	localparam int SEQ_OCODE_LSB = 34;
	localparam int MARKER_PARITY_LSB = 26;
	localparam logic [1:0] SYNC_DATA = 2'h1;
	localparam logic [1:0] SYNC_CTRL = 2'h2;
	localparam logic [7:0] TYPE_IDLE = 8'h1E;
	localparam logic [7:0] TYPE_ORDERED = 8'h4B;
	localparam logic [3:0] OCODE_SEQ = 4'h0;
	localparam logic [3:0] OCODE_SIGNAL = 4'hF;
	localparam logic [7:0] SEQ_LOCAL_FAULT = 8'h01;
	localparam logic [65:0] IDLE_BLK = {56'h0, TYPE_IDLE, SYNC_CTRL};
	// ==========================================================
	// Fault and error rate timing
	localparam int LF_SEQ_LIMIT = 4;
	localparam int LF_COL_WINDOW = 128;
	localparam int CLK_PERIOD_NS = 10;
	localparam int BER_WINDOW_NS = 500000;
	localparam int BER_WINDOW_CYCLES = BER_WINDOW_NS / CLK_PERIOD_NS;
	localparam int BER_ERR_LIMIT = 97;
	// ==========================================================
	// Register map (byte offsets) and reset values
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_STATUS = 4'h4;
	localparam logic [3:0] REG_MISMATCH_TOTAL = 4'h8;
	localparam logic [3:0] REG_PARITY_SEEN = 4'hC;
	localparam int CTRL_RX_TP_BIT = 0;
	localparam int ST_LOCAL_FAULT_BIT = 0;
	localparam int ST_HI_BER_BIT = 1;
	localparam int ST_SIGNAL_OS_BIT = 2;
	localparam int ST_INT_FAULT_BIT = 3;
	localparam int ST_TP_EN_BIT = 4;
	localparam logic [31:0] REG_RESET = 32'h0000_0000;
endpackage

// [hw/lane_parity_check.sv]
// Per-lane interleaved parity accumulation and check against lane markers
`timescale 1ns/1ps
module lane_parity_check
	import rx_pcs_lane_status_pkg::*;
#(
	parameter int LANES = NUM_LANES
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic reset_i,
	// Lane block stream
	input wire logic blk_valid_i,
	input wire logic [4:0] blk_lane_i,
	input wire logic [BLK_W-1:0] blk_i,
	input wire logic blk_marker_i,
	// Error pulses
	output logic [LANES-1:0] parity_err_o
);
	generate
		if (LANES < 1 || LANES > 32) begin : g_chk
			$error("lane_parity_check: LANES must be 1..32");
		end
	endgenerate

	// ==========================================================
	// Parity of one block, sync bits folded into columns 3 and 4
	function automatic logic [PARITY_W-1:0] blk_parity(input logic [BLK_W-1:0] b);
		logic [PARITY_W-1:0] p;
		p = '0;
		for (int i = 0; i < 64; i++) begin
			p[i % PARITY_W] = p[i % PARITY_W] ^ b[TYPE_LSB + i];
		end
		p[3] = p[3] ^ b[SYNC_LSB];
		p[4] = p[4] ^ b[SYNC_LSB + 1];
		return p;
	endfunction

	logic [PARITY_W-1:0] acc_ff [LANES];
	logic [PARITY_W-1:0] nxt_acc [LANES];
	logic [LANES-1:0] armed_ff;
	logic [LANES-1:0] nxt_armed;
	logic [LANES-1:0] err_ff;
	logic [LANES-1:0] nxt_err;

	// ==========================================================
	// Accumulate and compare per lane
	always_comb begin
		for (int l = 0; l < LANES; l++) begin
			nxt_acc[l] = acc_ff[l];
		end
		nxt_armed = armed_ff;
		nxt_err = '0;
		if (blk_valid_i && (int'(blk_lane_i) < LANES)) begin
			if (blk_marker_i) begin
				nxt_err[blk_lane_i] = armed_ff[blk_lane_i] &&
					(blk_i[MARKER_PARITY_LSB +: PARITY_W] != acc_ff[blk_lane_i]); // R4
				nxt_armed[blk_lane_i] = 1'b1;
				nxt_acc[blk_lane_i] = '0;
			end else begin
				nxt_acc[blk_lane_i] = acc_ff[blk_lane_i] ^ blk_parity(blk_i);
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			for (int l = 0; l < LANES; l++) begin
				acc_ff[l] <= '0;
			end
			armed_ff <= '0;
			err_ff <= '0;
		end else begin
			for (int l = 0; l < LANES; l++) begin
				acc_ff[l] <= nxt_acc[l];
			end
			armed_ff <= nxt_armed;
			err_ff <= nxt_err; // R5
		end
	end

	assign parity_err_o = err_ff; // R3

	// ==========================================================
	// Checks
	a_parity_one_lane: assert property (@(posedge clk_i) disable iff (reset_i)
		$onehot0(err_ff)) // R3
		else $error("parity error on more than one lane at once");
	a_parity_cause: assert property (@(posedge clk_i) disable iff (reset_i)
		|err_ff |-> $past(blk_valid_i && blk_marker_i)) // R4
		else $error("parity error without a marker");
endmodule

// [hw/rx_pcs_lane_status.sv]
// Receive PCS lane status, fault, error rate and test pattern check
//
// Functional notes
// R1 - Flag received local fault after enough sequences
// R2 - Local fault level holds while condition lasts
// R3 - One parity error flag per lane, 20 lanes
// R4 - Parity mismatch pulses lane flag one cycle
// R5 - Parity pulses may repeat back to back
// R6 - Excess error rate level while threshold exceeded
// R7 - Signal ordered set seen raises indication
// R8 - Partner should never send signal ordered sets
// R9 - Test enable checks against scrambled idle
// R10 - Test enable input maps to management bit
// R11 - Three-bit mismatch increment, only when enabled
// R12 - Internal fault on test, misalignment, error rate
// R13 - All status outputs registered, cleared by reset
`timescale 1ns/1ps
module rx_pcs_lane_status
	import rx_pcs_lane_status_pkg::*;
#(
	parameter int LANES = NUM_LANES,
	parameter int BLKS = BLKS_PER_CYCLE,
	parameter int BER_CYCLES = BER_WINDOW_CYCLES,
	parameter int BER_LIMIT = BER_ERR_LIMIT
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic reset_i,
	// Descrambled aggregate blocks
	input wire logic [BLKS-1:0] rx_blk_valid_i,
	input wire logic [BLKS-1:0][BLK_W-1:0] rx_blk_i,
	// Per-lane block stream
	input wire logic lane_blk_valid_i,
	input wire logic [4:0] lane_blk_lane_i,
	input wire logic [BLK_W-1:0] lane_blk_i,
	input wire logic lane_blk_marker_i,
	// Control
	input wire logic rx_test_pattern_i,
	input wire logic tx_test_pattern_i,
	input wire logic lanes_aligned_i,
	// Status
	output logic received_local_fault_o,
	output logic [LANES-1:0] lane_parity_err_o,
	output logic excess_error_rate_flag_o,
	output logic signal_ordered_set_seen_o,
	output logic internal_local_fault_o,
	output logic [MISMATCH_W-1:0] test_pattern_mismatch_o,
	// Avalon-MM slave
	input wire logic [3:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o
);
	generate
		if (BLKS < 1 || BLKS > 7 || BER_CYCLES < 2 ||
			BER_LIMIT < 1 || BER_LIMIT > 255) begin : g_chk
			$error("rx_pcs_lane_status: unsupported parameter values");
		end
	endgenerate

	// ==========================================================
	// Block decode
	function automatic logic is_ordered(input logic [BLK_W-1:0] b, input logic [3:0] oc);
		return b[SYNC_LSB +: 2] == SYNC_CTRL && b[TYPE_LSB +: 8] == TYPE_ORDERED &&
			b[SEQ_OCODE_LSB +: 4] == oc;
	endfunction

	logic any_valid;
	logic lf_seen;
	logic sig_seen;
	logic [7:0] bad_sync;
	logic [MISMATCH_W-1:0] mism;
	logic tp_en;
	logic ctrl_tp_ff;

	assign tp_en = rx_test_pattern_i | ctrl_tp_ff; // R10

	always_comb begin
		any_valid = |rx_blk_valid_i;
		lf_seen = 1'b0;
		sig_seen = 1'b0;
		bad_sync = '0;
		mism = '0;
		for (int i = 0; i < BLKS; i++) begin
			if (rx_blk_valid_i[i]) begin
				if (is_ordered(rx_blk_i[i], OCODE_SEQ) &&
					rx_blk_i[i][SEQ_D3_LSB +: 8] == SEQ_LOCAL_FAULT) begin
					lf_seen = 1'b1;
				end
				if (is_ordered(rx_blk_i[i], OCODE_SIGNAL)) begin
					sig_seen = 1'b1; // R7
				end
				if (rx_blk_i[i][SYNC_LSB +: 2] != SYNC_DATA &&
					rx_blk_i[i][SYNC_LSB +: 2] != SYNC_CTRL) begin
					bad_sync = bad_sync + 8'h01;
				end
				if (rx_blk_i[i] != IDLE_BLK) begin
					mism = mism + 3'h1; // R9
				end
			end
		end
	end

	// ==========================================================
	// Local fault detection
	typedef enum logic [2:0] {
		LF_IDLE = 3'b001,
		LF_COUNT = 3'b010,
		LF_FAULT = 3'b100
	} lf_state_t;

	lf_state_t lf_state_ff;
	lf_state_t nxt_lf_state;
	logic [2:0] seq_cnt_ff;
	logic [2:0] nxt_seq_cnt;
	logic [6:0] col_cnt_ff;
	logic [6:0] nxt_col_cnt;
	localparam logic [6:0] COL_LAST = 7'(LF_COL_WINDOW - 1);
	localparam logic [2:0] SEQ_LAST = 3'(LF_SEQ_LIMIT - 1);

	always_comb begin
		nxt_lf_state = lf_state_ff;
		nxt_seq_cnt = seq_cnt_ff;
		nxt_col_cnt = col_cnt_ff;
		unique case (lf_state_ff)
			LF_IDLE: begin
				if (lf_seen) begin
					nxt_lf_state = LF_COUNT;
					nxt_seq_cnt = 3'h1;
					nxt_col_cnt = '0;
				end
			end
			LF_COUNT: begin
				if (lf_seen) begin
					nxt_col_cnt = '0;
					nxt_seq_cnt = seq_cnt_ff + 3'h1;
					if (seq_cnt_ff == SEQ_LAST) begin
						nxt_lf_state = LF_FAULT; // R1
					end
				end else if (any_valid) begin
					nxt_col_cnt = col_cnt_ff + 7'h01;
					if (col_cnt_ff == COL_LAST) begin
						nxt_lf_state = LF_IDLE;
					end
				end
			end
			LF_FAULT: begin
				if (lf_seen) begin
					nxt_col_cnt = '0;
				end else if (any_valid) begin
					nxt_col_cnt = col_cnt_ff + 7'h01;
					if (col_cnt_ff == COL_LAST) begin
						nxt_lf_state = LF_IDLE; // R2
					end
				end
			end
			default: begin
				nxt_lf_state = LF_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			lf_state_ff <= LF_IDLE;
			seq_cnt_ff <= '0;
			col_cnt_ff <= '0;
		end else begin
			lf_state_ff <= nxt_lf_state;
			seq_cnt_ff <= nxt_seq_cnt;
			col_cnt_ff <= nxt_col_cnt;
		end
	end

	// ==========================================================
	// Error rate monitor over a fixed window
	logic [31:0] ber_tmr_ff;
	logic [31:0] nxt_ber_tmr;
	logic [8:0] ber_cnt_ff;
	logic [8:0] nxt_ber_cnt;
	logic hi_ber_ff;
	logic nxt_hi_ber;
	localparam logic [8:0] BER_LIM = 9'(BER_LIMIT);
	localparam logic [31:0] BER_LAST = 32'(BER_CYCLES - 1);

	always_comb begin
		nxt_ber_tmr = ber_tmr_ff + 32'h1;
		nxt_ber_cnt = ber_cnt_ff;
		nxt_hi_ber = hi_ber_ff;
		if (ber_cnt_ff < BER_LIM) begin
			nxt_ber_cnt = ber_cnt_ff + {1'b0, bad_sync};
		end
		if (nxt_ber_cnt >= BER_LIM) begin
			nxt_hi_ber = 1'b1; // R6
		end
		if (ber_tmr_ff == BER_LAST) begin
			nxt_ber_tmr = '0;
			nxt_ber_cnt = {1'b0, bad_sync};
			nxt_hi_ber = ber_cnt_ff + {1'b0, bad_sync} >= BER_LIM; // R6
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			ber_tmr_ff <= '0;
			ber_cnt_ff <= '0;
			hi_ber_ff <= 1'b0;
		end else begin
			ber_tmr_ff <= nxt_ber_tmr;
			ber_cnt_ff <= nxt_ber_cnt;
			hi_ber_ff <= nxt_hi_ber;
		end
	end

	// ==========================================================
	// Lane parity checker
	lane_parity_check #(
		.LANES(LANES)
	) u_parity (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.blk_valid_i(lane_blk_valid_i),
		.blk_lane_i(lane_blk_lane_i),
		.blk_i(lane_blk_i),
		.blk_marker_i(lane_blk_marker_i),
		.parity_err_o(lane_parity_err_o)
	);

	// ==========================================================
	// Registered status outputs
	logic rlf_ff;
	logic sig_ff;
	logic ilf_ff;
	logic [MISMATCH_W-1:0] mism_ff;
	logic nxt_rlf;
	logic nxt_ilf;
	logic [MISMATCH_W-1:0] nxt_mism;

	always_comb begin
		nxt_rlf = nxt_lf_state == LF_FAULT;
		nxt_ilf = tx_test_pattern_i | ~lanes_aligned_i | hi_ber_ff; // R12
		nxt_mism = tp_en ? mism : '0; // R11
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			rlf_ff <= 1'b0; // R13
			sig_ff <= 1'b0;
			ilf_ff <= 1'b0;
			mism_ff <= '0;
		end else begin
			rlf_ff <= nxt_rlf;
			sig_ff <= sig_seen; // R7
			ilf_ff <= nxt_ilf;
			mism_ff <= nxt_mism;
		end
	end

	assign received_local_fault_o = rlf_ff;
	assign excess_error_rate_flag_o = hi_ber_ff;
	assign signal_ordered_set_seen_o = sig_ff;
	assign internal_local_fault_o = ilf_ff;
	assign test_pattern_mismatch_o = mism_ff;

	// ==========================================================
	// Register slave: one wait cycle, then answer
	logic wait_ff;
	logic nxt_wait;
	logic [31:0] rdata_ff;
	logic [31:0] nxt_rdata;
	logic nxt_ctrl_tp;
	logic [31:0] tot_ff;
	logic [31:0] nxt_tot;
	logic [LANES-1:0] seen_ff;
	logic [LANES-1:0] nxt_seen;
	logic acc_wr;

	always_comb begin
		acc_wr = avs_write_i && !wait_ff;
		nxt_wait = !((avs_read_i || avs_write_i) && wait_ff);
		nxt_ctrl_tp = ctrl_tp_ff;
		nxt_tot = tot_ff + 32'(mism_ff);
		nxt_seen = seen_ff;
		nxt_rdata = rdata_ff;
		if (acc_wr && avs_address_i == REG_CTRL) begin
			nxt_ctrl_tp = avs_writedata_i[CTRL_RX_TP_BIT];
		end
		if (acc_wr && avs_address_i == REG_MISMATCH_TOTAL) begin
			nxt_tot = 32'(mism_ff);
		end
		if (acc_wr && avs_address_i == REG_PARITY_SEEN) begin
			nxt_seen = seen_ff & ~avs_writedata_i[LANES-1:0];
		end
		nxt_seen = nxt_seen | lane_parity_err_o;
		if (avs_read_i && wait_ff) begin
			unique case (avs_address_i)
				REG_CTRL: nxt_rdata = 32'(ctrl_tp_ff);
				REG_STATUS: nxt_rdata = 32'({tp_en, ilf_ff, sig_ff, hi_ber_ff, rlf_ff});
				REG_MISMATCH_TOTAL: nxt_rdata = tot_ff;
				REG_PARITY_SEEN: nxt_rdata = 32'(seen_ff);
				default: nxt_rdata = '0;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			wait_ff <= 1'b1;
			rdata_ff <= REG_RESET;
			ctrl_tp_ff <= 1'b0;
			tot_ff <= REG_RESET;
			seen_ff <= '0;
		end else begin
			wait_ff <= nxt_wait;
			rdata_ff <= nxt_rdata;
			ctrl_tp_ff <= nxt_ctrl_tp;
			tot_ff <= nxt_tot;
			seen_ff <= nxt_seen;
		end
	end

	assign avs_readdata_o = rdata_ff;
	assign avs_waitrequest_o = wait_ff;

	// ==========================================================
	// Checks
	sequence s_lf_burst;
		lf_seen [*4];
	endsequence

	a_lf_raise: assert property (@(posedge clk_i) disable iff (reset_i)
		(lf_state_ff == LF_IDLE) ##0 s_lf_burst |=> received_local_fault_o) // R1
		else $error("local fault not raised after four sequences");
	a_lf_hold: assert property (@(posedge clk_i) disable iff (reset_i)
		(lf_state_ff == LF_FAULT && lf_seen) |=> ##1 received_local_fault_o) // R2
		else $error("local fault dropped while sequences continue");
	a_parity_lane_index: assert property (@(posedge clk_i) disable iff (reset_i)
		(|lane_parity_err_o) |->
		lane_parity_err_o == (LANES'(1) << $past(lane_blk_lane_i))) // R3
		else $error("parity error flagged on the wrong lane");
	a_ber_level: assert property (@(posedge clk_i) disable iff (reset_i)
		(ber_cnt_ff >= BER_LIM) |-> hi_ber_ff) // R6
		else $error("error rate flag low above threshold");
	a_sigos_seen: assert property (@(posedge clk_i) disable iff (reset_i)
		(rx_blk_valid_i[0] && is_ordered(rx_blk_i[0], OCODE_SIGNAL)) |=>
		signal_ordered_set_seen_o) // R7
		else $error("signal ordered set not indicated");
	a_mism_gated: assert property (@(posedge clk_i) disable iff (reset_i)
		(test_pattern_mismatch_o != '0) |-> $past(tp_en)) // R11
		else $error("mismatch increment while checking disabled");
	a_tp_idle_check: assert property (@(posedge clk_i) disable iff (reset_i)
		(tp_en && rx_blk_valid_i[0] && rx_blk_i[0] != IDLE_BLK) |=>
		test_pattern_mismatch_o != '0) // R9
		else $error("non-idle block not counted as mismatch");
	a_int_fault: assert property (@(posedge clk_i) disable iff (reset_i)
		(!lanes_aligned_i || tx_test_pattern_i) |=> internal_local_fault_o) // R12
		else $error("internal fault missing");
	a_reset_clear: assert property (@(posedge clk_i)
		reset_i |=> !received_local_fault_o && !internal_local_fault_o &&
		lane_parity_err_o == '0 && test_pattern_mismatch_o == '0) // R13
		else $error("status not cleared by reset");
	a_bus_answer: assert property (@(posedge clk_i) disable iff (reset_i)
		(avs_read_i || avs_write_i) |-> ##[0:1] !avs_waitrequest_o) // R10
		else $error("bus request not answered within one cycle");
endmodule

// [verif/link_partner_model.sv]
// Link partner transmitter model feeding aggregate and per-lane block streams
`timescale 1ns/1ps
module link_partner_model
	import rx_pcs_lane_status_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic reset_i,
	// Commands from the bench
	input wire logic [2:0] kind_i,
	input wire logic [2:0] cnt_i,
	input wire logic [1:0] lane_cmd_i,
	input wire logic [4:0] lane_sel_i,
	input wire logic [63:0] pay_i,
	// Block streams
	output logic [3:0] blk_valid_o,
	output logic [3:0][65:0] blk_o,
	output logic lane_valid_o,
	output logic [4:0] lane_o,
	output logic [65:0] lane_blk_o,
	output logic lane_marker_o
);
	logic [NUM_LANES-1:0][7:0] acc_ff;
	logic [65:0] b;

	function automatic logic [7:0] par(input logic [65:0] v);
		logic [7:0] p;
		p = 8'h00;
		for (int i = 0; i < 64; i++) p[i % 8] ^= v[i + 2];
		p[3] ^= v[0];
		p[4] ^= v[1];
		return p;
	endfunction

	// ==========
	// Aggregate stream: first cnt blocks of the kind, rest idle
	always @(posedge clk_i) begin
		for (int i = 0; i < 4; i++) begin
			b = IDLE_BLK;
			if (i < cnt_i) begin
				case (kind_i)
					3'h2: b = {pay_i, SYNC_DATA};
					3'h3: b[37:2] = {OCODE_SEQ, SEQ_LOCAL_FAULT, 16'h0, TYPE_ORDERED};
					3'h4: b[37:2] = {OCODE_SIGNAL, 24'h0, TYPE_ORDERED};
					3'h5: b = {pay_i, 2'h3};
					default: ;
				endcase
			end
			// Released lanes show the inverse of the last block
			blk_o[i] <= (kind_i == 3'h0 && !reset_i) ? ~blk_o[i] : b;
		end
		blk_valid_o <= (reset_i || kind_i == 3'h0) ? 4'h0 : 4'hF;
	end

	// ==========
	// Lane stream: data, good marker, bad marker
	always @(posedge clk_i) begin
		lane_valid_o <= !reset_i && lane_cmd_i != 2'h0;
		lane_marker_o <= lane_cmd_i[1];
		lane_o <= lane_sel_i;
		if (reset_i) begin
			acc_ff <= '0;
			lane_blk_o <= IDLE_BLK;
		end else if (lane_cmd_i == 2'h1) begin
			lane_blk_o <= {pay_i, SYNC_DATA};
			acc_ff[lane_sel_i] <= acc_ff[lane_sel_i] ^ par({pay_i, SYNC_DATA});
		end else if (lane_cmd_i != 2'h0) begin
			lane_blk_o <= {pay_i[63:32], lane_cmd_i[0] ? ~acc_ff[lane_sel_i] :
				acc_ff[lane_sel_i], pay_i[23:0], SYNC_CTRL};
			acc_ff[lane_sel_i] <= 8'h00;
		end else begin
			lane_blk_o <= ~lane_blk_o;
		end
	end
endmodule

// [verif/tb.sv]
// Self-checking bench for the receive PCS lane status block
`timescale 1ns/1ps
module tb;
	import rx_pcs_lane_status_pkg::*;
	logic clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic [2:0] kind = 3'h0;
	logic [2:0] cnt = 3'h0;
	logic [1:0] lcmd = 2'h0;
	logic [4:0] lsel = 5'h00;
	logic [63:0] pay = 64'h0;
	logic rx_tp = 1'b0;
	logic tx_tp = 1'b0;
	logic aligned = 1'b1;
	logic [3:0] avs_addr = 4'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_wdata = 32'h0;
	logic [3:0] bv;
	logic [3:0][65:0] bk;
	logic lv, lm;
	logic [4:0] ln;
	logic [65:0] lb;
	logic received_local_fault_o, excess_error_rate_flag_o, signal_ordered_set_seen_o;
	logic internal_local_fault_o, avs_waitrequest_o;
	logic [19:0] lane_parity_err_o;
	logic [2:0] test_pattern_mismatch_o;
	logic [31:0] avs_readdata_o, r;
	logic [23:0] ev;
	logic [23:0] exp_q[$];
	logic [19:0] first_seen = 20'h0;
	logic tp_on = 1'b0;
	int bad_count = 0;
	int n_tests = 0;
	int seed = 32'hca275adc;

	initial forever #5 clk_i = ~clk_i;

	link_partner_model u_partner (.clk_i(clk_i), .reset_i(reset_i), .kind_i(kind), .cnt_i(cnt),
		.lane_cmd_i(lcmd), .lane_sel_i(lsel), .pay_i(pay), .blk_valid_o(bv), .blk_o(bk),
		.lane_valid_o(lv), .lane_o(ln), .lane_blk_o(lb), .lane_marker_o(lm));

	rx_pcs_lane_status #(.BER_CYCLES(64)) u_dut (.clk_i(clk_i), .reset_i(reset_i),
		.rx_blk_valid_i(bv), .rx_blk_i(bk), .lane_blk_valid_i(lv), .lane_blk_lane_i(ln),
		.lane_blk_i(lb), .lane_blk_marker_i(lm), .rx_test_pattern_i(rx_tp),
		.tx_test_pattern_i(tx_tp), .lanes_aligned_i(aligned),
		.received_local_fault_o(received_local_fault_o), .lane_parity_err_o(lane_parity_err_o),
		.excess_error_rate_flag_o(excess_error_rate_flag_o),
		.signal_ordered_set_seen_o(signal_ordered_set_seen_o),
		.internal_local_fault_o(internal_local_fault_o),
		.test_pattern_mismatch_o(test_pattern_mismatch_o), .avs_address_i(avs_addr),
		.avs_read_i(avs_read), .avs_write_i(avs_write), .avs_writedata_i(avs_wdata),
		.avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o));

	// ==========
	// Checking and closing
	task automatic close_out();
		$display("Comparisons %0d, mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic timeout();
		bad_count++;
		$display("MISMATCH wait exp done got timeout");
		close_out();
	endtask

	task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			bad_count++;
			$display("MISMATCH %s exp %h got %h", nm, e, g);
		end
	endtask

	task automatic chk_ev(logic [23:0] e, logic [23:0] g);
		n_tests++;
		if (g !== e) begin
			bad_count++;
			$display("MISMATCH event exp %h got %h", e, g);
		end
	endtask

	// Pulse outputs: each appearance takes the oldest note
	always @(negedge clk_i) begin
		if (!reset_i) begin
			ev = {test_pattern_mismatch_o, signal_ordered_set_seen_o, lane_parity_err_o};
			if (ev !== 24'h0) begin
				if (exp_q.size() == 0) chk_ev(24'h0, ev);
				else chk_ev(exp_q.pop_front(), ev);
			end
		end
	end

	initial begin
		repeat (100000) @(posedge clk_i);
		timeout();
	end

	// ==========
	// Drivers
	task automatic bus(logic wr, logic [3:0] a, logic [31:0] wd);
		int i;
		@(posedge clk_i);
		avs_read <= !wr;
		avs_write <= wr;
		avs_addr <= a;
		avs_wdata <= wd;
		for (i = 0; i < 20; i++) begin
			@(posedge clk_i);
			if (avs_waitrequest_o === 1'b0) break;
		end
		if (i == 20) timeout();
		r = avs_readdata_o;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask

	task automatic rchk(string nm, logic [3:0] a, logic [31:0] m, logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(nm, e, r & m);
	endtask

	task automatic agg(logic [2:0] k, logic [2:0] n, int c);
		logic [23:0] e;
		repeat (c) begin
			@(posedge clk_i);
			kind <= k;
			cnt <= n;
			pay <= {$random(seed), $random(seed)};
			e = {(tp_on && k > 3'h1) ? n : 3'h0, k == 3'h4 && n != 3'h0, 20'h0};
			if (e != 24'h0) exp_q.push_back(e);
		end
		@(posedge clk_i);
		kind <= 3'h0;
	endtask

	task automatic lane(int l, logic [1:0] c);
		@(posedge clk_i);
		lcmd <= c;
		lsel <= 5'(l);
		pay <= {$random(seed), $random(seed)};
		if (c == 2'h3 && first_seen[l]) exp_q.push_back(24'h1 << l);
		if (c[1]) first_seen[l] = 1'b1;
	endtask

	task automatic tp(logic pin, logic ctl);
		repeat (3) @(posedge clk_i);
		rx_tp <= pin;
		bus(1'b1, REG_CTRL, {31'h0, ctl});
		tp_on = pin | ctl;
		repeat (3) @(posedge clk_i);
	endtask

	function automatic logic lvl(int w);
		case (w)
			0: return received_local_fault_o;
			1: return excess_error_rate_flag_o;
			default: return internal_local_fault_o;
		endcase
	endfunction

	task automatic wait_lvl(int w, logic e);
		int i;
		for (i = 0; i < 300 && lvl(w) !== e; i++) @(posedge clk_i);
		if (i == 300) timeout();
		chk("level", {31'h0, e}, {31'h0, lvl(w)});
	endtask

	// ==========
	// Main sequence
	initial begin
		repeat (20) @(posedge clk_i);
		chk("reset outs", 32'h0, {lane_parity_err_o, received_local_fault_o,
			excess_error_rate_flag_o, signal_ordered_set_seen_o, internal_local_fault_o,
			test_pattern_mismatch_o});
		chk("reset wait", 32'h1, {31'h0, avs_waitrequest_o});
		reset_i <= 1'b0;
		rchk("ctrl", REG_CTRL, 32'hFFFFFFFF, REG_RESET);
		rchk("status", REG_STATUS, 32'hFFFFFFFF, REG_RESET);
		rchk("unmapped", 4'h2, 32'hFFFFFFFF, 32'h0);
		agg(3'h4, 3'h1, 2);
		agg(3'h2, 3'h4, 3);
		tp(1'b1, 1'b0);
		for (int n = 1; n <= 4; n++) agg(3'h2, 3'(n), 1);
		agg(3'h1, 3'h4, 2);
		rchk("tp on", REG_STATUS, 32'h10, 32'h10);
		tp(1'b0, 1'b1);
		agg(3'h2, 3'h3, 1);
		tp(1'b0, 1'b0);
		rchk("mism total", REG_MISMATCH_TOTAL, 32'hFFFFFFFF, 32'hD);
		bus(1'b1, REG_MISMATCH_TOTAL, 32'h0);
		rchk("mism reload", REG_MISMATCH_TOTAL, 32'hFFFFFFFF, 32'h0);
		agg(3'h3, 3'h1, 3);
		agg(3'h1, 3'h4, 200);
		chk("lf early", 32'h0, {31'h0, received_local_fault_o});
		agg(3'h3, 3'h1, 6);
		wait_lvl(0, 1'b1);
		agg(3'h1, 3'h4, 20);
		chk("lf hold", 32'h1, {31'h0, received_local_fault_o});
		agg(3'h1, 3'h4, 140);
		wait_lvl(0, 1'b0);
		@(posedge clk_i);
		tx_tp <= 1'b1;
		wait_lvl(2, 1'b1);
		@(posedge clk_i);
		tx_tp <= 1'b0;
		wait_lvl(2, 1'b0);
		@(posedge clk_i);
		aligned <= 1'b0;
		wait_lvl(2, 1'b1);
		@(posedge clk_i);
		aligned <= 1'b1;
		wait_lvl(2, 1'b0);
		agg(3'h5, 3'h4, 130);
		wait_lvl(1, 1'b1);
		wait_lvl(2, 1'b1);
		agg(3'h1, 3'h4, 200);
		wait_lvl(1, 1'b0);
		for (int l = 0; l < 20; l++) lane(l, 2'h3);
		for (int l = 0; l < 20; l++) begin
			lane(l, 2'h1);
			lane(l, 2'h1);
			lane(l, 2'h2);
			lane(l, 2'h1);
			lane(l, 2'h3);
		end
		lane(3, 2'h3);
		lane(3, 2'h3);
		lane(0, 2'h0);
		rchk("seen", REG_PARITY_SEEN, 32'hFFFFFFFF, 32'h000FFFFF);
		bus(1'b1, REG_PARITY_SEEN, 32'h000FFFFF);
		rchk("seen clr", REG_PARITY_SEEN, 32'hFFFFFFFF, 32'h0);
		repeat (5) @(posedge clk_i);
		chk("pending", 32'h0, exp_q.size());
		close_out();
	end
endmodule
